/* File: src/av_input_pkg.sv */
// shared constants, types and register map of the audio/video input formatter
package av_input_pkg;

  // ==========================================================================
  // register map
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_STATUS  = 12'h004;
  localparam logic [11:0] OFS_PKT_CNT = 12'h008;

  // control field positions
  localparam int CTRL_FMT_BIT  = 0;
  localparam int CTRL_NCH_LSB  = 1;
  localparam int CTRL_CS_LSB   = 5;
  localparam int CTRL_BPC_LSB  = 7;
  localparam int CTRL_QUAD_BIT = 9;
  localparam logic [31:0] CTRL_RST = 32'h0000_0004;  // two channels, pcm, rgb, 8 bit, dual

  // status field positions
  localparam int STS_TID_ERR_BIT = 0;
  localparam int STS_PEND_BIT    = 1;
  localparam int STS_FID_BIT     = 2;
  localparam int STS_TYPE_LSB    = 8;

  // ==========================================================================
  // audio
  localparam logic [7:0] PKT_TYPE_LPCM = 8'h02;
  localparam logic [7:0] PKT_TYPE_HBR  = 8'h09;
  localparam int MAX_CH      = 8;
  localparam int SLOT_W      = 24;
  localparam int LPCM_MSB    = 27;
  localparam int LPCM_W      = 24;
  localparam int HBR_MSB     = 27;
  localparam int HBR_W       = 16;

  typedef struct packed {
    logic [2:0]  tid;
    logic [31:0] data;
  } audio_beat_t;

  typedef struct packed {
    logic [7:0]               ptype;
    logic [3:0]               nch;
    logic [MAX_CH*SLOT_W-1:0] slots;
  } audio_pkt_t;

  // ==========================================================================
  // video
  localparam int IN_COMP_W = 16;
  localparam int NCOMP     = 3;

  typedef enum logic [1:0] {
    CS_RGB = 2'h0,
    CS_444 = 2'h1,
    CS_422 = 2'h2,
    CS_420 = 2'h3
  } color_space_t;

  // actual component width codes and the left shift that msb-aligns them
  localparam logic [1:0] BPC_8  = 2'h0;
  localparam logic [1:0] BPC_10 = 2'h1;
  localparam logic [1:0] BPC_12 = 2'h2;
  localparam logic [1:0] BPC_16 = 2'h3;
  localparam logic [3:0] SHIFT_8  = 4'h8;
  localparam logic [3:0] SHIFT_10 = 4'h6;
  localparam logic [3:0] SHIFT_12 = 4'h4;
  localparam logic [3:0] SHIFT_16 = 4'h0;

endpackage

/* File: src/av_input_formatter.sv */
// audio packer and video width/lane formatter with an apb register slave
`timescale 1ns/1ps

module av_input_formatter
  import av_input_pkg::*;
#(
  parameter int MAX_BPC   = 16,
  parameter int PPC_MAX   = 4,
  parameter bit REMAP_420 = 1'b1
) (
  input  wire logic                                sys_clk,
  input  wire logic                                sys_rst,
  // apb slave
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [11:0]                         paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  // audio stream in
  input  wire logic                                audio_valid,
  input  wire audio_beat_t                         audio_in,
  output logic                                     audio_ready,
  // packed audio out
  output logic                                     pkt_valid,
  output audio_pkt_t                               pkt_out,
  input  wire logic                                pkt_ready,
  // video stream in
  input  wire logic                                vid_valid,
  input  wire logic                                vid_sof,
  input  wire logic                                vid_fid,
  input  wire logic [PPC_MAX*NCOMP*IN_COMP_W-1:0]  vid_data,
  // native video out
  output logic                                     vout_valid,
  output logic                                     vout_sof,
  output logic                                     vout_fid,
  output logic      [PPC_MAX*NCOMP*MAX_BPC-1:0]    vout_data
);

  // ==========================================================================
  // registers and apb slave
  logic [31:0] ctrl_ff;
  logic        tid_err_ff;
  logic [15:0] pkt_cnt_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic        fid_ff;
  logic        pend_ff;
  audio_pkt_t  pkt_ff;

  logic        apb_xfer;
  logic        apb_wr;
  logic        addr_ok;
  logic [31:0] rd_mux;

  assign apb_xfer = psel && penable && pready_ff;
  assign apb_wr   = apb_xfer && pwrite;
  assign addr_ok  = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) || (paddr == OFS_PKT_CNT);

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL:    rd_mux = ctrl_ff;
      OFS_STATUS: begin
        rd_mux[STS_TID_ERR_BIT]            = tid_err_ff;
        rd_mux[STS_PEND_BIT]               = pend_ff;
        rd_mux[STS_FID_BIT]                = fid_ff;
        rd_mux[STS_TYPE_LSB +: 8]          = pkt_ff.ptype;
      end
      OFS_PKT_CNT: rd_mux = {16'h0000, pkt_cnt_ff};
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait state so that pready, prdata and pslverr all come from flops
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= psel && penable && !pready_ff;
      pslverr_ff <= psel && penable && !pready_ff && !addr_ok;
      if (psel && penable && !pready_ff && !pwrite) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  // control register, written at the edge where pready is sampled high
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_ff <= CTRL_RST;
    end else if (apb_wr && (paddr == OFS_CTRL)) begin
      ctrl_ff <= pwdata;
    end
  end

  logic         fmt_hbr;
  logic [3:0]   nch_cfg;
  color_space_t cs_cfg;
  logic [1:0]   bpc_cfg;
  logic         quad_cfg;

  assign fmt_hbr  = ctrl_ff[CTRL_FMT_BIT];
  assign nch_cfg  = ctrl_ff[CTRL_NCH_LSB +: 4];
  assign cs_cfg   = color_space_t'(ctrl_ff[CTRL_CS_LSB +: 2]);
  assign bpc_cfg  = ctrl_ff[CTRL_BPC_LSB +: 2];
  assign quad_cfg = ctrl_ff[CTRL_QUAD_BIT];

  // ==========================================================================
  // audio packing
  logic [2:0] slot_ff;
  logic [2:0] last_slot;
  logic       take;
  logic       pkt_done;
  logic       pkt_taken;
  logic       ready_ff;

  // zero or out-of-range channel counts are clamped to 1..8
  always_comb begin
    if (nch_cfg == 4'h0) begin
      last_slot = 3'h0;
    end else if (nch_cfg > 4'(MAX_CH)) begin
      last_slot = 3'(MAX_CH - 1);
    end else begin
      last_slot = 3'(nch_cfg - 4'h1);
    end
  end

  assign take      = audio_valid && ready_ff;
  assign pkt_done  = take && (slot_ff == last_slot);
  assign pkt_taken = pend_ff && pkt_ready;

  // slot pointer follows arrival order, not the tag, so a misordered source
  // lands in the wrong slot rather than stalling the stream
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      slot_ff <= 3'h0;
    end else if (pkt_done) begin
      slot_ff <= 3'h0;
    end else if (take) begin
      slot_ff <= slot_ff + 3'h1;
    end
  end

  // slot store; compressed words keep bits 27:12 zero-extended, pcm words keep bits 27:4
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pkt_ff <= '0;
    end else if (take) begin
      if (fmt_hbr) begin
        pkt_ff.slots[slot_ff*SLOT_W +: SLOT_W] <=
          {8'h00, audio_in.data[HBR_MSB -: HBR_W]};
      end else begin
        pkt_ff.slots[slot_ff*SLOT_W +: SLOT_W] <=
          audio_in.data[LPCM_MSB -: LPCM_W];
      end
      if (pkt_done) begin
        pkt_ff.ptype <= fmt_hbr ? PKT_TYPE_HBR : PKT_TYPE_LPCM;
        pkt_ff.nch   <= 4'({1'b0, last_slot} + 4'h1);
      end
    end
  end

  // packet pending flag, packet counter and ready back-pressure
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pend_ff    <= 1'b0;
      ready_ff   <= 1'b0;
      pkt_cnt_ff <= 16'h0000;
    end else begin
      pend_ff  <= pkt_done || (pend_ff && !pkt_ready);
      ready_ff <= !(pkt_done || (pend_ff && !pkt_ready));
      if (pkt_taken) begin
        pkt_cnt_ff <= pkt_cnt_ff + 16'h0001;
      end
    end
  end

  // tag mismatch is sticky; a new mismatch beats a write-one clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tid_err_ff <= 1'b0;
    end else if (take && (audio_in.tid != slot_ff)) begin
      tid_err_ff <= 1'b1;
    end else if (apb_wr && (paddr == OFS_STATUS) && pwdata[STS_TID_ERR_BIT]) begin
      tid_err_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // video formatting
  logic [3:0] shamt;
  logic       remap_on;

  // 4:2:2 ignores the configured width and is always 12 bit
  always_comb begin
    if (cs_cfg == CS_422) begin
      shamt = SHIFT_12;
    end else begin
      unique case (bpc_cfg)
        BPC_8:   shamt = SHIFT_8;
        BPC_10:  shamt = SHIFT_10;
        BPC_12:  shamt = SHIFT_12;
        BPC_16:  shamt = SHIFT_16;
        default: shamt = SHIFT_16;
      endcase
    end
  end

  assign remap_on = REMAP_420 && (cs_cfg == CS_420);

  logic [PPC_MAX*NCOMP*MAX_BPC-1:0] nxt_vout_data;

  // msb-align each component in 16 bits then keep the top MAX_BPC bits;
  // one shift covers truncation and zero padding alike
  for (genvar g = 0; g < PPC_MAX*NCOMP; g++) begin : g_comp
    localparam int PIX = g / NCOMP;
    localparam int CMP = g % NCOMP;
    localparam int SWP = (CMP == 0) ? 1 : ((CMP == 1) ? 0 : CMP);
    logic [IN_COMP_W-1:0] src;
    logic [IN_COMP_W-1:0] aligned;
    assign src = remap_on ? vid_data[(PIX*NCOMP+SWP)*IN_COMP_W +: IN_COMP_W]
                          : vid_data[g*IN_COMP_W +: IN_COMP_W];
    assign aligned = src << shamt;
    assign nxt_vout_data[g*MAX_BPC +: MAX_BPC] =
      (quad_cfg || (PIX < 2)) ? aligned[IN_COMP_W-1 -: MAX_BPC]
                              : '0;
  end

  // single register stage, no line buffer in the path
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      vout_valid    <= 1'b0;
      vout_sof      <= 1'b0;
      vout_data     <= '0;
    end else begin
      vout_valid    <= vid_valid;
      vout_sof      <= vid_valid && vid_sof;
      vout_data     <= nxt_vout_data;
    end
  end

  // field parity is only meaningful at start of frame
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fid_ff <= 1'b0;
    end else if (vid_valid && vid_sof) begin
      fid_ff <= vid_fid;
    end
  end

  assign vout_fid    = fid_ff;
  assign audio_ready = ready_ff;
  assign pkt_valid   = pend_ff;
  assign pkt_out     = pkt_ff;
  assign prdata      = prdata_ff;
  assign pready      = pready_ff;
  assign pslverr     = pslverr_ff;

  // ==========================================================================
  // assertions
  AST_SLOT_ADVANCE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!take && !sys_rst) |=> (slot_ff == $past(slot_ff)))
    else $error("slot pointer moved without a handshake");

  AST_SLOT_ORDER: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && !pkt_done) |=> (slot_ff == $past(slot_ff) + 3'h1))
    else $error("slot pointer did not follow arrival order");

  AST_PKT_TYPE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pkt_done |=> (pkt_ff.ptype == ($past(fmt_hbr) ? PKT_TYPE_HBR : PKT_TYPE_LPCM)))
    else $error("packet type does not match audio format");

  AST_PCM_BITS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && !fmt_hbr) |=> (pkt_ff.slots[$past(slot_ff)*SLOT_W +: SLOT_W]
                            == $past(audio_in.data[LPCM_MSB -: LPCM_W])))
    else $error("pcm slot does not hold 24 sample bits");

  AST_HBR_BITS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && fmt_hbr) |=> (pkt_ff.slots[$past(slot_ff)*SLOT_W +: SLOT_W]
                           == {8'h00, $past(audio_in.data[HBR_MSB -: HBR_W])}))
    else $error("hbr slot does not hold bits 27:12");

  AST_BACKPRESSURE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (pend_ff && !pkt_ready) |=> !audio_ready ##0 pkt_valid)
    else $error("ready high while packet still pending");

  AST_TID_ERR: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && (audio_in.tid != slot_ff)) |=> tid_err_ff ##1
      (tid_err_ff || $past(apb_wr && (paddr == OFS_STATUS) && pwdata[STS_TID_ERR_BIT])))
    else $error("channel tag mismatch not flagged");

  // ready and a pending packet never coexist, or a sample would overwrite a slot
  AST_READY_PEND: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pkt_valid |-> !audio_ready)
    else $error("audio ready high while a packet is pending");

  // a waiting packet must not change under the consumer
  AST_PKT_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (pkt_valid && !pkt_ready) |=> (pkt_valid && $stable(pkt_out)))
    else $error("pending packet changed before it was taken");

  AST_422_DEPTH: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (vid_valid && (cs_cfg == CS_422)) |->
      ##1 (vout_data[MAX_BPC-1:0] ==
           $past(16'(vid_data[IN_COMP_W-1:0] << SHIFT_12)) >> (IN_COMP_W - MAX_BPC)))
    else $error("4:2:2 component not treated as 12 bit");

  AST_WIDTH_MAP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (vid_valid && !remap_on && (cs_cfg != CS_422) && (bpc_cfg == BPC_16)) |=>
      (vout_data[MAX_BPC-1:0] == $past(vid_data[IN_COMP_W-1 -: MAX_BPC])))
    else $error("16 bit component not truncated to its top bits");

  AST_NO_BUFFER: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(vid_valid) |=> vout_valid ##1 (vout_valid == $past(vid_valid)))
    else $error("video path latency is not one cycle");

  AST_FID_SAMPLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (vid_valid && vid_sof) |=> (vout_fid == $past(vid_fid)) && vout_sof)
    else $error("field parity not captured at start of frame");

endmodule

/* File: testbench/av_source_model.sv */
// audio stream source model feeding channel-tagged samples
`timescale 1ns/1ps

module av_source_model
  import av_input_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic [3:0]  nch,
  input  wire logic [3:0]  used,
  input  wire logic        slow,
  input  wire logic        bad,
  input  wire logic [31:0] base,
  input  wire logic        audio_ready,
  output logic             audio_valid,
  output audio_beat_t      audio_in,
  output logic             busy
);
  logic [3:0] idx_ff;

  // ==========================================================================
  // sequencer: slow mode idles one cycle after each accepted sample
  always @(posedge sys_clk) begin : seq
    logic [3:0] nxt_idx;
    nxt_idx = idx_ff + {3'h0, audio_valid};
    if (sys_rst) begin
      audio_valid <= 1'b0;
      audio_in    <= '0;
      busy        <= 1'b0;
      idx_ff      <= 4'h0;
    end else if (start && !busy) begin
      busy   <= 1'b1;
      idx_ff <= 4'h0;
    end else if (busy && (!audio_valid || audio_ready)) begin
      idx_ff <= nxt_idx;
      if (nxt_idx == nch || (slow && audio_valid)) begin
        audio_valid   <= 1'b0;
        audio_in.data <= ~audio_in.data;  // released data never echoes the last sample
        busy          <= (nxt_idx != nch);
      end else begin
        audio_valid   <= 1'b1;
        audio_in.tid  <= nxt_idx[2:0] ^ {2'h0, bad};
        audio_in.data <= (nxt_idx < used) ? base ^ (32'(nxt_idx) * 32'h0111_1111) : 32'h0;
      end
    end
  end
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the audio/video input formatter
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end

module testbench
  import av_input_pkg::*;
;
  localparam int MB = 12;
  logic           sys_clk = 1'b0;
  logic           sys_rst = 1'b1;
  logic           psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]    paddr = '0;
  logic [31:0]    pwdata = '0, prdata;
  logic           pready, pslverr, audio_valid, audio_ready, pkt_valid, pkt_ready = 1'b0;
  audio_beat_t    audio_in;
  audio_pkt_t     pkt_out;
  logic           vid_valid = 1'b0, vid_sof = 1'b0, vid_fid = 1'b0;
  logic [191:0]   vid_data = '0;
  logic           vout_valid, vout_sof, vout_fid, busy, start = 1'b0, slow = 1'b0, bad = 1'b0;
  logic [143:0]   vout_data;
  logic [3:0]     nch = 4'h0, used = 4'h0;
  logic [31:0]    base = '0;
  int             bad_count = 0, samples_checked = 0;

  // ==========================================================================
  // clock, design and source model
  always #10 sys_clk = ~sys_clk;

  av_input_formatter #(.MAX_BPC(MB), .PPC_MAX(4), .REMAP_420(1'b1)) av_input_formatter_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .audio_valid(audio_valid), .audio_in(audio_in), .audio_ready(audio_ready),
    .pkt_valid(pkt_valid), .pkt_out(pkt_out), .pkt_ready(pkt_ready), .vid_valid(vid_valid),
    .vid_sof(vid_sof), .vid_fid(vid_fid), .vid_data(vid_data), .vout_valid(vout_valid),
    .vout_sof(vout_sof), .vout_fid(vout_fid), .vout_data(vout_data));

  av_source_model av_source_model_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .start(start), .nch(nch), .used(used),
    .slow(slow), .bad(bad), .base(base), .audio_ready(audio_ready),
    .audio_valid(audio_valid), .audio_in(audio_in), .busy(busy));

  // ==========================================================================
  // verdict and bounded waits
  task automatic complete_run();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // a wait that runs out is a mismatch and ends the run; sel high watches ready
  task automatic wait_for(input logic sel, input logic v);
    int n;
    n = 0;
    while ((sel ? audio_ready : pkt_valid) !== v && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 200) begin
      bad_count++;
      complete_run();
    end
  endtask

  // apb transfer: request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      complete_run();
    end
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(r, x)
    `CHK(e, xe)
  endtask

  // ==========================================================================
  // one audio packet; downstream stalls five cycles before taking it
  task automatic audio_pkt(input logic fmt, input logic [3:0] n, input logic [3:0] u,
                           input logic sl, input logic bt, input logic [31:0] b);
    int          k;
    logic [31:0] d;
    logic [23:0] s;
    wr(OFS_CTRL, {27'h0, n, fmt});
    nch <= n;
    used <= u;
    slow <= sl;
    bad <= bt;
    base <= b;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    wait_for(1'b0, 1'b1);
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK(audio_ready, 1'b0)
    `CHK(pkt_out.ptype, fmt ? PKT_TYPE_HBR : PKT_TYPE_LPCM)
    `CHK(pkt_out.nch, n)
    for (k = 0; k < int'(n); k++) begin
      d = (k < int'(u)) ? b ^ (32'(k) * 32'h0111_1111) : 32'h0;
      s = fmt ? {8'h00, d[27:12]} : d[27:4];
      `CHK(pkt_out.slots[k*SLOT_W+:SLOT_W], s)
    end
    @(posedge sys_clk);
    pkt_ready <= 1'b1;
    @(posedge sys_clk);
    pkt_ready <= 1'b0;
    wait_for(1'b1, 1'b1);
    `CHK(pkt_valid, 1'b0)
  endtask

  // one video beat; expected lanes msb-aligned to the configured maximum
  task automatic vid(input logic [1:0] cs, input logic [1:0] code, input logic q,
                     input logic f);
    logic [191:0] din;
    logic [143:0] e;
    logic [15:0]  v, x;
    int           p, c, w;
    wr(OFS_CTRL, {22'h0, q, code, cs, 5'h0});
    w = (cs == 2'h2) ? 12 : (code == 2'h0) ? 8 : (code == 2'h1) ? 10 : (code == 2'h2) ? 12 : 16;
    for (p = 0; p < 4; p++) begin
      for (c = 0; c < 3; c++) begin
        v = (16'hf00d ^ 16'(p * 16'h1357 + c * 16'h0b21)) & 16'((32'h1 << w) - 1);
        din[(p*3+c)*16+:16] = v;
        x = (w > MB) ? v >> (w - MB) : v << (MB - w);
        e[(p*3+((cs == 2'h3 && c < 2) ? 1 - c : c))*MB+:MB] = (p < 2 || q) ? x[MB-1:0] : '0;
      end
    end
    vid_valid <= 1'b1;
    vid_sof <= 1'b1;
    vid_fid <= f;
    vid_data <= din;
    @(posedge sys_clk);
    vid_valid <= 1'b0;
    vid_sof <= 1'b0;
    vid_fid <= ~f;
    vid_data <= ~din;
    #1;
    `CHK({vout_valid, vout_sof, vout_fid}, {2'b11, f})
    `CHK(vout_data, e)
    @(posedge sys_clk);
    `CHK(vout_fid, f)
  endtask

  // ==========================================================================
  // main sequence
  initial begin : main
    int i;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd_chk(OFS_CTRL, CTRL_RST, 1'b0);
    rd_chk(12'h0fc, 32'h0, 1'b1);
    wr(12'h0fc, 32'hffff_ffff);
    audio_pkt(1'b0, 4'h4, 4'h3, 1'b0, 1'b0, 32'h0a5c_3e71);
    audio_pkt(1'b1, 4'h8, 4'h8, 1'b1, 1'b0, 32'h0f1e_2d3c);
    wr(OFS_PKT_CNT, 32'h0);
    rd_chk(OFS_PKT_CNT, 32'h2, 1'b0);
    rd_chk(OFS_STATUS, 32'h0000_0900, 1'b0);
    // swapped tags still land by arrival order and raise the sticky mismatch
    audio_pkt(1'b0, 4'h2, 4'h2, 1'b0, 1'b1, 32'h0c33_5aa5);
    rd_chk(OFS_STATUS, 32'h0000_0201, 1'b0);
    wr(OFS_STATUS, 32'h0000_0001);
    for (i = 0; i < 16; i++) begin
      vid(i[3:2], i[1:0], i[0] ^ i[2], i[1]);
    end
    rd_chk(OFS_STATUS, 32'h0000_0204, 1'b0);
    complete_run();
  end
endmodule
